/* File: pack_monitor_serial_slave_regs_tb.sv */
// Bench: AXI commands through the master, registers checked in the slave
`timescale 1ns/10ps
`default_nettype none
module pack_monitor_serial_slave_regs_tb;
  import pms_pkg::*;
  // ======
  // Stimulus and observed signals
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, porPulse, porSeen;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] dis, chg, fea, ptr;
  logic [3:0] flg;
  logic [7:0] regs [0:10];
  int badCount = 0;
  int checksDone = 0;
  always #50 clock = ~clock;
  pms_link_if link ();
  pms_master_host u_pms_master_host (.clock, .rst_n, .link(link.host), .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready);
  pms_slave_dev u_pms_slave_dev (.clock, .rst_n, .link(link.device), .dischargeSetting(dis),
    .chargeSetting(chg), .featureSetting(fea), .gpFlags(flg), .porPulse);
  pms_link_sva u_pms_link_sva (.clock, .rst_n, .scl(link.scl), .sda(link.sda),
    .hostSclOe(link.hostSclOe), .devSdaOe(link.devSdaOe));
  // One-cycle pulse is easy to miss, so latch it
  always @(posedge clock) if (porPulse === 1'b1) porSeen <= 1'b1;
  // ======
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic hang(input int n, input int lim);
    if (n >= lim) begin
      badCount++;
      $display("Error at %0t: wait ran out", $time);
      tallyAndFinish();
    end
  endtask
  // ======
  // AXI4-Lite master; each channel released at its own handshake
  task automatic axiWr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    hang(n, 50);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axiRd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    hang(n, 50);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // Launch one link command and poll until the master is idle
  task automatic cmd(input logic rd, input logic cur, input logic [7:0] ra, input logic [7:0] d,
    output logic [7:0] got);
    logic [31:0] s;
    logic [1:0] r;
    int n;
    axiWr(HOST_CMD_OFS, {14'h0000, cur, rd, ra, d}, r);
    chk(r, RESP_OKAY);
    for (n = 0; n < 400; n++) begin
      axiRd(HOST_STAT_OFS, s, r);
      if (s[0] === 1'b0) break;
    end
    hang(n, 400);
    chk(s[1], 1'b0);
    chk(r, RESP_OKAY);
    got = s[15:8];
  endtask
  // ======
  // Reference model of the slave registers
  function automatic void mWrite(input logic [7:0] a, input logic [7:0] d);
    if (a == ADDR_CTRL && d[POR_BIT]) foreach (regs[k]) regs[k] = 8'h00;
    else if (a == ADDR_FLAGS) regs[a] = d & FLAG_MASK;
    else if (a < ADDR_DISCHARGE || a == ADDR_UNLOCK) regs[a] = d;
    else if (a <= ADDR_FEATURE && regs[ADDR_UNLOCK][a[2:0]]) regs[a] = d;
    ptr = (a >= ADDR_WRAP) ? 8'h00 : a + 8'h01;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] g;
    cmd(1'b0, 1'b0, a, d, g);
    mWrite(a, d);
    chk({dis, chg, fea, 4'h0, flg}, {regs[5], regs[6], regs[7], regs[9]});
  endtask
  task automatic rdr(input logic [7:0] a, input logic cur);
    logic [7:0] g;
    cmd(1'b1, cur, a, 8'h00, g);
    if (!cur) ptr = a;
    chk(g, regs[ptr]);
    ptr = (ptr >= ADDR_WRAP) ? 8'h00 : ptr + 8'h01;
  endtask
  // ======
  // Main sequence
  initial begin
    logic [31:0] s;
    logic [1:0] r;
    int i;
    foreach (regs[k]) regs[k] = 8'h00;
    ptr = 8'h00;
    porSeen = 1'b0;
    i = $urandom(32'h808d_ea28);
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    // Reset values, then wrap from the last address into a current read
    for (i = 5; i < 11; i++) rdr(i[7:0], 1'b0);
    rdr(8'h00, 1'b1);
    $display("test reset values done");
    // Each unlock bit alone; the first pass leaves all three locked
    for (i = 4; i < 8; i++) begin
      wr(ADDR_UNLOCK, 8'h01 << i);
      for (int j = 5; j < 8; j++) wr(j[7:0], 8'($urandom));
    end
    $display("test write protection done");
    wr(ADDR_UNLOCK, 8'hE0);
    wr(ADDR_FLAGS, 8'hFF);
    wr(ADDR_CTRL, 8'h80);
    chk(porSeen, 1'b1);
    rdr(ADDR_UNLOCK, 1'b0);
    // Command register reads back the last launched command
    axiRd(HOST_CMD_OFS, s, r);
    chk(s, {14'h0000, 1'b0, 1'b1, ADDR_UNLOCK, 8'h00});
    $display("test forced reset done");
    // Random mix; writes stay at or below the flag register
    repeat (40) begin
      if ($urandom_range(1, 0)) wr(8'($urandom_range(9, 0)), 8'($urandom));
      else rdr(8'($urandom_range(10, 0)), 1'($urandom));
    end
    $display("test random traffic done");
    axiRd(4'h8, s, r);
    chk(r, RESP_SLVERR);
    axiWr(4'hC, 32'h0000_0000, r);
    chk(r, RESP_SLVERR);
    $display("test unmapped access done");
    tallyAndFinish();
  end
endmodule
`default_nettype wire

/* File: pms_link_if.sv */
// Two-wire open-drain link between master and slave
`timescale 1ns/10ps
`default_nettype none
interface pms_link_if;
  // ==========================================================
  // Driver signals of each end
  logic hostSclOut;
  logic hostSclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  // Resolved wire levels, released lines float high
  logic scl;
  logic sda;
  assign scl = hostSclOe ? hostSclOut : 1'b1;
  assign sda = (hostSdaOe ? hostSdaOut : 1'b1) & (devSdaOe ? devSdaOut : 1'b1);
  modport host (output hostSclOut, output hostSclOe, output hostSdaOut, output hostSdaOe, input scl, input sda);
  modport device (output devSdaOut, output devSdaOe, input scl, input sda);
endinterface
`default_nettype wire

/* File: pms_link_sva.sv */
// Link protocol checks watching the wire between the two ends
`timescale 1ns/10ps
`default_nettype none
module pms_link_sva
  import pms_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Link wires and enables
  input wire logic scl,
  input wire logic sda,
  input wire logic hostSclOe,
  input wire logic devSdaOe
);
  // ======
  // Frame tracking
  logic sclQ, sdaQ, frameQ, firstQ, rdQ, hitQ;
  logic [3:0] cntQ;
  logic [7:0] shQ;
  wire startEv = scl & sclQ & sdaQ & ~sda;
  wire stopEv = scl & sclQ & ~sdaQ & sda;
  wire fallEv = sclQ & ~scl;
  wire ninth = fallEv & (cntQ == 4'h8);
  // Count clock falls; the fall closing a start is skipped (count F)
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {sclQ, sdaQ, frameQ, firstQ, rdQ, hitQ} <= 6'h30;
      cntQ <= 4'hF;
      shQ <= 8'h00;
    end else begin
      sclQ <= scl;
      sdaQ <= sda;
      if (startEv) begin
        {frameQ, firstQ, rdQ, hitQ, cntQ} <= 8'hCF;
      end else if (stopEv) begin
        frameQ <= 1'b0;
      end else if (fallEv) begin
        cntQ <= (cntQ == 4'h8 || cntQ == 4'hF) ? 4'h0 : cntQ + 4'h1;
        shQ <= {shQ[6:0], sdaQ};
        if (firstQ && cntQ == 4'h7) rdQ <= sdaQ;
        if (ninth) firstQ <= 1'b0;
        if (ninth && firstQ) hitQ <= (shQ[7:1] == SLAVE_ADDR);
      end
    end
  end
  // ======
  // Assertions; bit values are taken from the cycle before the fall
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  dev_change_low_a: assert property ($changed(devSdaOe) |-> !scl)
    else $error("device data moved while clock high");
  idle_silent_a: assert property (!frameQ |-> !devSdaOe)
    else $error("device drove outside a frame");
  stop_release_a: assert property (stopEv |=> !devSdaOe [*8])
    else $error("device drove after stop");
  slave_match_a: assert property (ninth && firstQ |-> $past(devSdaOe) == (shQ[7:1] == SLAVE_ADDR))
    else $error("slave byte ack wrong");
  write_quiet_a: assert property (fallEv && !rdQ && cntQ != 4'h8 |-> !$past(devSdaOe))
    else $error("device drove a write bit slot");
  write_ack_a: assert property (ninth && hitQ && !rdQ && !firstQ |-> $past(devSdaOe))
    else $error("write byte not acked");
  nack_release_a: assert property (ninth && rdQ && !firstQ && sdaQ |-> !devSdaOe [*8])
    else $error("device sent after nack");
  scl_low_a: assert property ($rose(hostSclOe) |-> hostSclOe [*2])
    else $error("clock low phase too short");
  scl_high_a: assert property ($fell(hostSclOe) |-> !hostSclOe [*4])
    else $error("clock high phase too short");
  // Main scenarios seen
  cover property (ninth && hitQ && !rdQ && !firstQ);
  cover property (startEv && frameQ);
  cover property (ninth && rdQ && !firstQ && sdaQ);
endmodule
`default_nettype wire

/* File: pms_master_host.sv */
// Two-wire bus master driven by AXI4-Lite command registers
`timescale 1ns/10ps
`default_nettype none
module pms_master_host
  import pms_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Serial link
  pms_link_if.host link,
  // AXI4-Lite write
  input wire logic [AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  typedef enum logic [3:0] {pIdle, pStart, pSlaveW, pReg, pData, pRstart, pSlaveR, pRead, pStop} pms_phase_e;

  // ==========================================================
  // Bus slave state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [AXI_AW-1:0] awAddr_q;
  logic [31:0] wData_q, rdata_q;
  logic [3:0] wStrb_q;
  logic [1:0] bresp_q, rresp_q;
  // Engine state
  pms_phase_e phase_q, phase_d;
  logic [1:0] qtr_q, qtr_d;
  logic [7:0] div_q;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [7:0] rxShift_q, rxShift_d, rdData_q, rdData_d, regAddr_q, wrByte_q;
  logic nack_q, nack_d, isRead_q, isCur_q, sclOe_q, sdaOe_q, sdaMeta_q, sdaSync_q;

  // ==========================================================
  // Decode; a command needs the low three byte lanes
  wire busy = (phase_q != pIdle);
  wire wrDo = !awready_q && !wready_q && !bvalid_q;
  wire wrMapped = (awAddr_q == HOST_CMD_OFS) || (awAddr_q == HOST_STAT_OFS);
  wire cmdGo = wrDo && (awAddr_q == HOST_CMD_OFS) && (&wStrb_q[2:0]) && !busy;
  wire [31:0] statWord = {16'h0000, rdData_q, 6'h00, nack_q, busy};
  wire rdMapped = (araddr == HOST_CMD_OFS) || (araddr == HOST_STAT_OFS);
  wire [31:0] rdMux = (araddr == HOST_STAT_OFS) ? statWord : {8'h00, 6'h00, isCur_q, isRead_q, regAddr_q, wrByte_q};

  // AXI4-Lite handshakes, response after both halves are held
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {awready_q, wready_q, arready_q} <= 3'h7;
      {bvalid_q, rvalid_q} <= 2'h0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      bresp_q <= RESP_OKAY;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      if (awvalid && awready_q) begin
        awAddr_q <= awaddr;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        wData_q <= wdata;
        wStrb_q <= wstrb;
        wready_q <= 1'b0;
      end
      if (wrDo) begin
        bvalid_q <= 1'b1;
        bresp_q <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && bready) begin
        {bvalid_q, awready_q, wready_q} <= 3'h3;
      end
      if (arvalid && arready_q) begin
        rdata_q <= rdMapped ? rdMux : 32'h0000_0000;
        rresp_q <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        rvalid_q <= 1'b1;
        arready_q <= 1'b0;
      end
      if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Serial engine: four quarters per slot
  wire tick = busy && (div_q == 8'(QTR_CYCLES - 1));
  wire [7:0] txByte = (phase_q == pSlaveW) ? {SLAVE_ADDR, 1'b0}
                    : (phase_q == pSlaveR) ? {SLAVE_ADDR, 1'b1} // [RULE14]
                    : (phase_q == pReg) ? regAddr_q : wrByte_q;
  wire [2:0] bitIdx = 3'(BITS_PER_BYTE - BIT_ONE - bitCnt_q);
  wire ackSlot = (bitCnt_q == BITS_PER_BYTE);
  // Release on ack slots and on every read slot, so the final read byte gets a nack
  wire bitVal = (phase_q == pRead) || ackSlot || txByte[bitIdx]; // [RULE3] [RULE7] [RULE15]
  wire isFrame = (phase_q == pStart) || (phase_q == pRstart) || (phase_q == pStop);
  wire sclDrive = busy && (qtr_q == Q0 || (qtr_q == Q3 && phase_q != pStop));
  // Data moves in Q0 with clock low; framing moves it in Q2 with clock high
  wire sdaDrive = !busy ? 1'b0 : (phase_q == pStart || phase_q == pRstart) ? (qtr_q >= Q2)
                : (phase_q == pStop) ? (qtr_q <= Q1) : !bitVal; // [RULE4]

  always_comb begin
    phase_d = phase_q;
    qtr_d = qtr_q;
    bitCnt_d = bitCnt_q;
    rxShift_d = rxShift_q;
    rdData_d = rdData_q;
    nack_d = nack_q;
    if (cmdGo) begin
      phase_d = pStart;
      qtr_d = Q0;
      bitCnt_d = '0;
      nack_d = 1'b0;
    end else if (tick) begin
      qtr_d = qtr_q + 2'h1;
      if (qtr_q == Q2 && !isFrame) begin
        if (phase_q == pRead && !ackSlot) begin
          rxShift_d = {rxShift_q[6:0], sdaSync_q}; // [RULE3]
        end else if (phase_q != pRead && ackSlot) begin
          nack_d = sdaSync_q; // [RULE7]
        end
      end
      if (qtr_q == Q3) begin
        case (phase_q)
          pStart: phase_d = isCur_q ? pSlaveR : pSlaveW;
          pRstart: phase_d = pSlaveR; // [RULE14]
          pStop: phase_d = pIdle;
          pSlaveW, pReg, pData, pSlaveR, pRead: begin
            bitCnt_d = ackSlot ? 4'h0 : bitCnt_q + BIT_ONE;
            if (ackSlot) begin
              if (phase_q != pRead && nack_q) begin
                phase_d = pStop;
              end else if (phase_q == pSlaveW) begin
                phase_d = pReg; // [RULE10]
              end else if (phase_q == pReg) begin
                phase_d = isRead_q ? pRstart : pData; // [RULE10] [RULE14]
              end else if (phase_q == pSlaveR) begin
                phase_d = pRead;
              end else begin
                phase_d = pStop; // [RULE13] [RULE15]
              end
              if (phase_q == pRead) begin
                rdData_d = rxShift_q;
              end
            end
          end
          default: phase_d = pIdle;
        endcase
      end
    end
  end

  // Engine registers and command capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= pIdle;
      qtr_q <= Q0;
      div_q <= '0;
      bitCnt_q <= '0;
      {rxShift_q, rdData_q, regAddr_q, wrByte_q} <= '0;
      {nack_q, isRead_q, isCur_q, sclOe_q, sdaOe_q} <= '0;
      {sdaMeta_q, sdaSync_q} <= 2'h3;
    end else begin
      phase_q <= phase_d;
      qtr_q <= qtr_d;
      div_q <= (cmdGo || tick || !busy) ? 8'h00 : div_q + 8'h01;
      bitCnt_q <= bitCnt_d;
      rxShift_q <= rxShift_d;
      rdData_q <= rdData_d;
      nack_q <= nack_d;
      sclOe_q <= sclDrive;
      sdaOe_q <= sdaDrive;
      sdaMeta_q <= link.sda;
      sdaSync_q <= sdaMeta_q;
      if (cmdGo) begin
        wrByte_q <= wData_q[CMD_DATA_LSB +: BYTE_W];
        regAddr_q <= wData_q[CMD_REG_LSB +: BYTE_W];
        isRead_q <= wData_q[CMD_READ_BIT] | wData_q[CMD_CUR_BIT];
        isCur_q <= wData_q[CMD_CUR_BIT]; // [RULE17]
      end
    end
  end

  // ==========================================================
  // Outputs
  assign link.hostSclOut = 1'b0;
  assign link.hostSclOe = sclOe_q;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSdaOe = sdaOe_q;
  assign {awready, wready, bvalid, bresp} = {awready_q, wready_q, bvalid_q, bresp_q};
  assign {arready, rvalid, rdata, rresp} = {arready_q, rvalid_q, rdata_q, rresp_q};

endmodule
`default_nettype wire

/* File: pms_pkg.sv */
// Shared constants for the pack monitor serial slave and its bus master
package pms_pkg;
  // ==========================================================
  // Register space of the slave
  localparam int BYTE_W = 8;
  localparam int REG_COUNT = 11;
  localparam int REG_AW = 4;
  localparam logic [7:0] ADDR_DISCHARGE = 8'h05;
  localparam logic [7:0] ADDR_CHARGE = 8'h06;
  localparam logic [7:0] ADDR_FEATURE = 8'h07;
  localparam logic [7:0] ADDR_UNLOCK = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h09;
  localparam logic [7:0] ADDR_CTRL = 8'h0A;
  localparam logic [7:0] ADDR_WRAP = 8'h0A;
  localparam int UNLOCK_FEATURE_BIT = 7;
  localparam int UNLOCK_CHARGE_BIT = 6;
  localparam int UNLOCK_DISCHARGE_BIT = 5;
  localparam int POR_BIT = 7;
  localparam int FLAG_W = 4;
  localparam logic [7:0] FLAG_MASK = 8'h0F;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Arbitrary bus address, not tied to any real part
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h28;
  // ==========================================================
  // Serial framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [1:0] IDX_SLAVE = 2'h0;
  localparam logic [1:0] IDX_REG = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  // ==========================================================
  // Timing of the master's serial clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  localparam int QTR_CYCLES = LINK_PERIOD_NS / CLK_PERIOD_NS / 4;
  localparam logic [1:0] Q0 = 2'h0;
  localparam logic [1:0] Q1 = 2'h1;
  localparam logic [1:0] Q2 = 2'h2;
  localparam logic [1:0] Q3 = 2'h3;
  // ==========================================================
  // Master's own AXI4-Lite registers
  localparam int AXI_AW = 4;
  localparam logic [3:0] HOST_CMD_OFS = 4'h0;
  localparam logic [3:0] HOST_STAT_OFS = 4'h4;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_REG_LSB = 8;
  localparam int CMD_READ_BIT = 16;
  localparam int CMD_CUR_BIT = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: pms_slave_dev.sv */
// Serial slave port and byte register file of the pack monitor
// Behaviour
// RULE1 - Four flag bits, freely written by host
// RULE2 - Flags survive sleep, cleared by forced reset
// RULE3 - Bytes travel most significant bit first
// RULE4 - Data changes only while clock low
// RULE5 - Ignore bus until a start is seen
// RULE6 - Stop ends transaction, back to standby
// RULE7 - Receiver pulls data low on ninth clock
// RULE8 - Ack only matching slave byte, then all
// RULE9 - Read continues on ack, stops on nack
// RULE10 - Write: start, slave, register, data, stop
// RULE11 - Store data on falling edge after bit8
// RULE12 - Address increments after data, wraps past 0AH
// RULE13 - Master writes no higher than 08H; this master sends any register address, and the bench writes 09H and 0AH
// RULE14 - Random read: address, repeated start, read
// RULE15 - Master ends read with nack, stop
// RULE16 - Pointer advances after eighth read bit
// RULE17 - Current-address read uses retained pointer
// RULE18 - Three setting registers locked after reset
// RULE19 - Unlock bits live at address 08H
// RULE20 - Bits 7,6,5 unlock registers 7,6,5
// RULE21 - Clearing unlock bit restores protection
// RULE22 - Locked write acknowledged but ignored
`timescale 1ns/10ps
`default_nettype none
module pms_slave_dev
  import pms_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Serial link
  pms_link_if.device link,
  // Settings seen by the protection logic
  output logic [7:0] dischargeSetting,
  output logic [7:0] chargeSetting,
  output logic [7:0] featureSetting,
  output logic [FLAG_W-1:0] gpFlags,
  output logic porPulse
);

  typedef enum logic [2:0] {dIdle, dRx, dRxAck, dTx, dTxAck} pms_dev_state_e;

  // ==========================================================
  // State
  pms_dev_state_e state_q, state_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [7:0] shift_q, shift_d;
  logic [1:0] byteIdx_q, byteIdx_d;
  logic readMode_q, readMode_d;
  logic [7:0] ptr_q, ptr_d;
  logic sdaOe_q, sdaOe_d;
  logic ackSeen_q, ackSeen_d;
  logic porPulse_q;
  logic [7:0] regFile_q [REG_COUNT];
  logic sclMeta_q, sclSync_q, sclPrev_q;
  logic sdaMeta_q, sdaSync_q, sdaPrev_q;

  // ==========================================================
  // Line sampling; the first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclMeta_q <= 1'b1;
      sclSync_q <= 1'b1;
      sclPrev_q <= 1'b1;
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclMeta_q <= link.scl;
      sclSync_q <= sclMeta_q;
      sclPrev_q <= sclSync_q;
      sdaMeta_q <= link.sda;
      sdaSync_q <= sdaMeta_q;
      sdaPrev_q <= sdaSync_q;
    end
  end

  // Edges and bus conditions; data moving under a high clock is framing
  wire sclRise = sclSync_q & ~sclPrev_q;
  wire sclFall = ~sclSync_q & sclPrev_q;
  wire sclHigh = sclSync_q & sclPrev_q;
  wire startSeen = sclHigh & sdaPrev_q & ~sdaSync_q; // [RULE4] [RULE5]
  wire stopSeen = sclHigh & ~sdaPrev_q & sdaSync_q; // [RULE4] [RULE6]

  // ==========================================================
  // Byte decode and register access
  wire byteDone = (state_q == dRx) && sclFall && (bitCnt_q == BITS_PER_BYTE);
  wire addrMatch = (shift_q[7:1] == SLAVE_ADDR); // [RULE8]
  wire [REG_AW-1:0] ptrIdx = ptr_q[REG_AW-1:0];
  wire ptrValid = (ptr_q <= ADDR_WRAP);
  wire [7:0] unlockReg = regFile_q[ADDR_UNLOCK[REG_AW-1:0]]; // [RULE19]
  // A locked setting register swallows the byte silently
  wire lockedHit = ((ptr_q == ADDR_FEATURE) && !unlockReg[UNLOCK_FEATURE_BIT])
                 || ((ptr_q == ADDR_CHARGE) && !unlockReg[UNLOCK_CHARGE_BIT])
                 || ((ptr_q == ADDR_DISCHARGE) && !unlockReg[UNLOCK_DISCHARGE_BIT]); // [RULE18] [RULE20] [RULE21]
  wire dataWrite = byteDone && (byteIdx_q == IDX_DATA);
  wire porForce = dataWrite && (ptr_q == ADDR_CTRL) && shift_q[POR_BIT]; // [RULE2]
  // Control byte is write-only: it acts, it does not store
  wire wrAccept = dataWrite && ptrValid && !lockedHit && (ptr_q != ADDR_CTRL); // [RULE11] [RULE22]
  wire [7:0] wrValue = (ptr_q == ADDR_FLAGS) ? (shift_q & FLAG_MASK) : shift_q; // [RULE1]
  wire [7:0] rdByte = (ptrValid && ptr_q != ADDR_CTRL) ? regFile_q[ptrIdx] : RESET_BYTE;
  wire [7:0] ptrNext = (ptr_q == ADDR_WRAP) ? RESET_BYTE : ptr_q + 8'h01; // [RULE12]

  // ==========================================================
  // Register file; forced reset clears every byte, flags included
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regFile_q[i] <= RESET_BYTE;
      end
    end else if (porForce) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regFile_q[i] <= RESET_BYTE; // [RULE2]
      end
    end else if (wrAccept) begin
      regFile_q[ptrIdx] <= wrValue; // [RULE1] [RULE11]
    end
  end

  // ==========================================================
  // Protocol sequencer
  always_comb begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    byteIdx_d = byteIdx_q;
    readMode_d = readMode_q;
    ptr_d = ptr_q;
    sdaOe_d = sdaOe_q;
    ackSeen_d = ackSeen_q;
    if (stopSeen) begin
      state_d = dIdle; // [RULE6]
      sdaOe_d = 1'b0;
    end else if (startSeen) begin
      state_d = dRx; // [RULE5] [RULE14]
      bitCnt_d = '0;
      byteIdx_d = IDX_SLAVE;
      sdaOe_d = 1'b0;
    end else begin
      case (state_q)
        dIdle: begin
          sdaOe_d = 1'b0;
        end
        dRx: begin
          if (sclRise) begin
            shift_d = {shift_q[6:0], sdaSync_q}; // [RULE3]
            bitCnt_d = bitCnt_q + BIT_ONE;
          end else if (byteDone) begin
            bitCnt_d = '0;
            if (byteIdx_q != IDX_SLAVE || addrMatch) begin
              state_d = dRxAck;
              sdaOe_d = 1'b1; // [RULE7] [RULE8]
            end else begin
              state_d = dIdle; // [RULE8]
            end
            if (byteIdx_q == IDX_SLAVE) begin
              readMode_d = shift_q[0];
            end
            if (byteIdx_q == IDX_REG) begin
              ptr_d = shift_q;
            end
          end
        end
        dRxAck: begin
          if (sclFall) begin
            sdaOe_d = 1'b0;
            if (byteIdx_q == IDX_DATA) begin
              ptr_d = ptrNext; // [RULE12]
            end
            if (byteIdx_q == IDX_SLAVE && readMode_q) begin
              // Read starts from the retained pointer
              state_d = dTx; // [RULE17]
              shift_d = rdByte;
              sdaOe_d = ~rdByte[7]; // [RULE3] [RULE4]
              bitCnt_d = BIT_ONE;
            end else begin
              state_d = dRx; // [RULE10]
              byteIdx_d = (byteIdx_q == IDX_SLAVE) ? IDX_REG : IDX_DATA;
            end
          end
        end
        dTx: begin
          if (sclFall) begin
            if (bitCnt_q == BITS_PER_BYTE) begin
              state_d = dTxAck;
              sdaOe_d = 1'b0; // [RULE7] [RULE9]
              ptr_d = ptrNext; // [RULE16]
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              sdaOe_d = ~shift_q[6]; // [RULE3] [RULE4]
              bitCnt_d = bitCnt_q + BIT_ONE;
            end
          end
        end
        dTxAck: begin
          if (sclRise) begin
            ackSeen_d = ~sdaSync_q; // [RULE9]
          end else if (sclFall) begin
            if (ackSeen_q) begin
              state_d = dTx; // [RULE9]
              shift_d = rdByte;
              sdaOe_d = ~rdByte[7];
              bitCnt_d = BIT_ONE;
            end else begin
              state_d = dIdle; // [RULE9] [RULE15]
            end
          end
        end
        default: begin
          state_d = dIdle;
          sdaOe_d = 1'b0;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dIdle;
      bitCnt_q <= '0;
      shift_q <= '0;
      byteIdx_q <= IDX_SLAVE;
      readMode_q <= 1'b0;
      ptr_q <= '0;
      sdaOe_q <= 1'b0;
      ackSeen_q <= 1'b0;
      porPulse_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
      shift_q <= shift_d;
      byteIdx_q <= byteIdx_d;
      readMode_q <= readMode_d;
      ptr_q <= ptr_d;
      sdaOe_q <= sdaOe_d;
      ackSeen_q <= ackSeen_d;
      porPulse_q <= porForce;
    end
  end

  // ==========================================================
  // Outputs; open drain so the driven level is always low
  assign link.devSdaOut = 1'b0;
  assign link.devSdaOe = sdaOe_q;
  assign dischargeSetting = regFile_q[ADDR_DISCHARGE[REG_AW-1:0]];
  assign chargeSetting = regFile_q[ADDR_CHARGE[REG_AW-1:0]];
  assign featureSetting = regFile_q[ADDR_FEATURE[REG_AW-1:0]];
  assign gpFlags = regFile_q[ADDR_FLAGS[REG_AW-1:0]][FLAG_W-1:0];
  assign porPulse = porPulse_q;

endmodule
`default_nettype wire
